// ---- core/epas_emulated_partner.sv ----
// Emulated link partner: negotiation result, expansion and special words.
// Assumes the host word port and the management port are driven by logic
// on core_clk; only the strap arrives from a pin.
//
// Operation
// - Partner pause pair follows the local pause bits, with the strap choosing when both are set.
// - Partner reports 100BASE-X and 10BASE-T full and half duplex once negotiation completes; its word reads zero from reset until then.
// - Each word is 32 bits with 31:16 zero, and 16 bits on the management port.
// - Expansion word sits at byte 1d8 and management index 6.
// - Parallel detection fault bit 4 always reads zero.
// - Next-page bits 3 and 2 always read zero.
// - Page-received bit 1 is zero at reset, set by negotiation, cleared by a read.
// - Bit 0 reads one unless negotiation finds no common ability.
// - Special control/status word sits at byte 1dc and management index 31.
// - Partner pause pair is latched only when negotiation completes.
`timescale 1ns/1ps
`default_nettype none
module epas_emulated_partner
  import epas_pkg::*;
#(
  parameter int AN_WAIT = AN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [HOST_ADDR_W-1:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  input wire logic [4:0] mgmt_index,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic [15:0] local_ability_advert_word,
  input wire logic an_enable,
  input wire logic an_restart,
  input wire logic [2:0] speed_duplex,
  input wire logic pause_result_select_strap,
  output logic [15:0] partner_ability,
  output logic an_complete,
  output logic collision_test_en
);

  localparam int CNT_W = $clog2(AN_WAIT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(AN_WAIT - 1);

  // Pause pair of the partner, returned as {asym, sym}
  function automatic logic [1:0] pause_result(
    input logic sym,
    input logic asym,
    input logic strap
  );
    logic [1:0] res;
    res = 2'b00;
    if (sym && !asym) begin
      res = 2'b01;
    end else if (!sym && asym) begin
      res = 2'b11;
    end else if (sym && asym) begin
      res = strap ? 2'b11 : 2'b10;
    end
    return res;
  endfunction

  // Word returned for a selected register
  function automatic logic [REG_W-1:0] read_word(
    input logic sel_exp,
    input logic sel_scs,
    input logic [REG_W-1:0] exp_word,
    input logic [REG_W-1:0] scs_word
  );
    logic [REG_W-1:0] w;
    w = '0;
    if (sel_exp) begin
      w = exp_word;
    end else if (sel_scs) begin
      w = scs_word;
    end
    return w;
  endfunction

  epas_an_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic start_pend_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic page_rx_reg;
  logic lp_an_reg;
  logic coll_reg;
  logic [15:0] lp_word_reg;
  logic [31:0] host_rdata_reg;
  logic host_rvalid_reg;
  logic [15:0] mgmt_rdata_reg;
  logic mgmt_rvalid_reg;

  // Address decode for both access paths
  // expansion and special control/status decode
  wire host_sel_exp = (host_addr == EXP_OFFSET);
  wire mgmt_sel_exp = (mgmt_index == EXP_INDEX);
  wire host_sel_scs = (host_addr == SCS_OFFSET);
  wire mgmt_sel_scs = (mgmt_index == SCS_INDEX);

  wire exp_read = (host_rd && host_sel_exp) || (mgmt_rd && mgmt_sel_exp);
  wire host_scs_wr = host_wr && host_sel_scs;
  wire mgmt_scs_wr = mgmt_wr && mgmt_sel_scs;

  wire adv_sym = local_ability_advert_word[ADV_SYM_BIT];
  wire adv_asym = local_ability_advert_word[ADV_ASYM_BIT];
  wire [ABIL_W-1:0] adv_abil =
    local_ability_advert_word[ADV_ABIL_LSB +: ABIL_W];
  wire common_ok = |(adv_abil & LP_ABIL);
  wire [1:0] pause_pair = pause_result(adv_sym, adv_asym, strap_sync_reg);

  wire an_start = an_enable && (start_pend_reg || an_restart);
  wire an_finish = (state_reg == EPAS_AN_RUN) && an_enable &&
    (cnt_reg == CNT_LAST);

  // Expansion word assembly
  logic [REG_W-1:0] exp_word;
  always_comb begin
    exp_word = '0;
    exp_word[EXP_PDF_BIT] = 1'b0;
    exp_word[EXP_LP_NP_BIT] = 1'b0;
    exp_word[EXP_LOC_NP_BIT] = 1'b0;
    exp_word[EXP_PAGE_RX_BIT] = page_rx_reg;
    exp_word[EXP_LP_AN_BIT] = lp_an_reg;
  end

  logic [REG_W-1:0] scs_word;
  always_comb begin
    scs_word = '0;
    scs_word[SCS_COLL_BIT] = coll_reg;
    scs_word[SCS_SPD_LSB +: 3] = speed_duplex;
  end

  // Partner base page built at completion
  logic [15:0] lp_word_new;
  always_comb begin
    lp_word_new = '0;
    lp_word_new[4:0] = LP_SELECTOR;
    lp_word_new[LP_ABIL_LSB +: ABIL_W] = LP_ABIL;
    lp_word_new[LP_SYM_BIT] = pause_pair[0];
    lp_word_new[LP_ASYM_BIT] = pause_pair[1];
    lp_word_new[LP_ACK_BIT] = 1'b1;
  end

  // Negotiation sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      EPAS_AN_IDLE: begin
        if (an_start) begin
          state_next = EPAS_AN_RUN;
          cnt_next = '0;
        end
      end
      EPAS_AN_RUN: begin
        if (!an_enable) begin
          state_next = EPAS_AN_IDLE;
        end else if (an_finish) begin
          state_next = EPAS_AN_DONE;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      EPAS_AN_DONE: begin
        if (!an_enable) begin
          state_next = EPAS_AN_IDLE;
        end else if (an_restart) begin
          state_next = EPAS_AN_RUN;
          cnt_next = '0;
        end
      end
      default: begin
        state_next = EPAS_AN_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= EPAS_AN_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // First run after reset is automatic
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_pend_reg <= 1'b1;
    end else if (state_reg == EPAS_AN_RUN) begin
      start_pend_reg <= 1'b0;
    end
  end

  // Strap pin synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      strap_meta_reg <= pause_result_select_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // set on completion wins over read clear
  logic page_rx_next;
  always_comb begin
    page_rx_next = page_rx_reg;
    if (an_finish) begin
      page_rx_next = 1'b1;
    end else if (exp_read) begin
      page_rx_next = 1'b0;
    end
  end

  // expansion word has no write path
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_rx_reg <= PAGE_RX_RESET;
    end else begin
      page_rx_reg <= page_rx_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lp_word_reg <= LP_WORD_RESET;
      lp_an_reg <= LP_AN_RESET;
    end else if (an_finish) begin
      lp_word_reg <= lp_word_new;
      lp_an_reg <= common_ok;
    end
  end

  // Collision test control; host write wins a tie
  logic coll_next;
  always_comb begin
    coll_next = coll_reg;
    if (host_scs_wr) begin
      coll_next = host_wdata[SCS_COLL_BIT];
    end else if (mgmt_scs_wr) begin
      coll_next = mgmt_wdata[SCS_COLL_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coll_reg <= COLL_RESET;
    end else begin
      coll_reg <= coll_next;
    end
  end

  // 16-bit words, upper host half reads zero
  wire [REG_W-1:0] host_word =
    read_word(host_sel_exp, host_sel_scs, exp_word, scs_word);
  wire [REG_W-1:0] mgmt_word =
    read_word(mgmt_sel_exp, mgmt_sel_scs, exp_word, scs_word);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_rdata_reg <= 32'h0000_0000;
      host_rvalid_reg <= 1'b0;
      mgmt_rdata_reg <= 16'h0000;
      mgmt_rvalid_reg <= 1'b0;
    end else begin
      host_rvalid_reg <= host_rd;
      mgmt_rvalid_reg <= mgmt_rd;
      if (host_rd) begin
        host_rdata_reg <= {16'h0000, host_word};
      end
      if (mgmt_rd) begin
        mgmt_rdata_reg <= mgmt_word;
      end
    end
  end

  assign host_rdata = host_rdata_reg;
  assign host_rvalid = host_rvalid_reg;
  assign mgmt_rdata = mgmt_rdata_reg;
  assign mgmt_rvalid = mgmt_rvalid_reg;
  assign partner_ability = lp_word_reg;
  assign an_complete = (state_reg == EPAS_AN_DONE);
  assign collision_test_en = coll_reg;

endmodule
`default_nettype wire

// ---- pkg/epas_pkg.sv ----
// Constants, field layout and state encoding of the emulated partner block.
// Assumes a 50 MHz core clock; all users import the whole package.
package epas_pkg;

  // Clock and negotiation timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int AN_TIME_NS = 1000;
  localparam int AN_CYCLES = (AN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register locations
  localparam int HOST_ADDR_W = 12;
  localparam logic [11:0] EXP_OFFSET = 12'h1d8;
  localparam logic [11:0] SCS_OFFSET = 12'h1dc;
  localparam logic [4:0] EXP_INDEX = 5'h06;
  localparam logic [4:0] SCS_INDEX = 5'h1f;
  localparam int REG_W = 16;

  // Expansion status word fields
  localparam int EXP_PDF_BIT = 4;
  localparam int EXP_LP_NP_BIT = 3;
  localparam int EXP_LOC_NP_BIT = 2;
  localparam int EXP_PAGE_RX_BIT = 1;
  localparam int EXP_LP_AN_BIT = 0;
  localparam logic PAGE_RX_RESET = 1'b0;
  localparam logic LP_AN_RESET = 1'b1;

  // Special control/status word fields
  localparam int SCS_COLL_BIT = 7;
  localparam int SCS_SPD_LSB = 2;
  localparam logic COLL_RESET = 1'b0;

  // Local advertisement fields
  localparam int ADV_SYM_BIT = 10;
  localparam int ADV_ASYM_BIT = 11;
  localparam int ADV_ABIL_LSB = 5;
  localparam int ABIL_W = 4;

  // Emulated partner base page fields
  localparam int LP_ACK_BIT = 14;
  localparam int LP_ASYM_BIT = 11;
  localparam int LP_SYM_BIT = 10;
  localparam int LP_ABIL_LSB = 5;
  localparam logic [3:0] LP_ABIL = 4'hf;
  localparam logic [4:0] LP_SELECTOR = 5'h01;
  localparam logic [15:0] LP_WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    EPAS_AN_IDLE = 3'b001,
    EPAS_AN_RUN = 3'b010,
    EPAS_AN_DONE = 3'b100
  } epas_an_state_t;

endpackage

// ---- testbench/epas_checker.sv ----
// Port assertions for the emulated partner block.
// Bound into the emulated partner module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module epas_checker
  import epas_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic [4:0] mgmt_index,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic [15:0] local_ability_advert_word,
  input wire logic pause_result_select_strap,
  input wire logic [15:0] partner_ability,
  input wire logic an_complete,
  input wire logic collision_test_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic hx = host_rd && host_addr == EXP_OFFSET;
  wire logic [15:0] adv = local_ability_advert_word;
  property p_up; host_rvalid |-> host_rdata[31:16] == 16'h0; endproperty
  a_up: assert property (p_up) else $error("upper half not zero");
  property p_hx; hx |=> host_rdata[31:2] == 30'h0; endproperty
  a_hx: assert property (p_hx) else $error("fixed bits wrong");
  property p_mx;
    mgmt_rd && mgmt_index == EXP_INDEX |=> mgmt_rdata[15:2] == 14'h0;
  endproperty
  a_mx: assert property (p_mx) else $error("serial word wrong");
  property p_abil;
    an_complete |-> partner_ability[8:0] == {LP_ABIL, LP_SELECTOR};
  endproperty
  a_abil: assert property (p_abil) else $error("abilities wrong");
  property p_pause;
    $rose(an_complete) |-> partner_ability[11] == $past(adv[11]) &&
      partner_ability[10] == $past(adv[10] ^ adv[11] |
      adv[10] & adv[11] & pause_result_select_strap);
  endproperty
  a_pause: assert property (p_pause) else $error("pause pair wrong");
  property p_hold;
    an_complete && $past(an_complete) |-> $stable(partner_ability);
  endproperty
  a_hold: assert property (p_hold) else $error("pause moved");
  property p_clr; hx && an_complete ##1 hx && an_complete |=>
    !host_rdata[EXP_PAGE_RX_BIT]; endproperty
  a_clr: assert property (p_clr) else $error("page flag kept");
  property p_colm; mgmt_wr && mgmt_index == SCS_INDEX && !host_wr |=>
    collision_test_en == $past(mgmt_wdata[7]); endproperty
  a_colm: assert property (p_colm) else $error("serial write lost");
  property p_colh; host_wr && host_addr == SCS_OFFSET |=>
    collision_test_en == $past(host_wdata[7]); endproperty
  a_colh: assert property (p_colh) else $error("host write lost");
  c_an: cover property ($rose(an_complete));
  c_rd: cover property (hx && an_complete);
  c_wr: cover property (mgmt_wr && mgmt_index == SCS_INDEX);
endmodule
bind epas_emulated_partner epas_checker chk (.core_clk, .rst, .host_addr,
  .host_rd, .host_wr, .host_wdata, .host_rdata, .host_rvalid, .mgmt_index,
  .mgmt_rd, .mgmt_wr, .mgmt_wdata, .mgmt_rdata, .local_ability_advert_word,
  .pause_result_select_strap, .partner_ability, .an_complete,
  .collision_test_en);
`default_nettype wire

// ---- testbench/epas_emulated_partner_bench.sv ----
// Self-checking bench for the emulated partner block.
// Host port driven here, serial port through the master model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module epas_emulated_partner_bench
  import epas_pkg::*;
;
  logic core_clk = 0, rst = 1, host_rd = 0, host_wr = 0, an_enable = 0;
  logic an_restart = 0, pause_result_select_strap = 0, an_complete;
  logic host_rvalid, mgmt_rd, mgmt_wr, mgmt_rvalid, collision_test_en;
  logic [11:0] host_addr = 12'h000;
  logic [31:0] host_wdata = 32'h0, host_rdata, he;
  logic [15:0] local_ability_advert_word = 16'h0, mgmt_wdata, mgmt_rdata;
  logic [15:0] partner_ability, pa, me;
  logic [4:0] mgmt_index;
  logic [2:0] speed_duplex = 3'h1, sd;
  logic [3:0] ab;
  logic [31:0] hq[$];
  logic [15:0] mq[$];
  logic [2:0] tbl[5] = '{3'h0, 3'h1, 3'h6, 3'h3, 3'h7};
  integer seed = 32'hed76;
  int err_count = 0, compares = 0, n, i;
  always #10 core_clk = ~core_clk;
  epas_emulated_partner #(.AN_WAIT(2)) dut (.core_clk, .rst, .host_addr,
    .host_rd, .host_wr, .host_wdata, .host_rdata, .host_rvalid,
    .mgmt_index, .mgmt_rd, .mgmt_wr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid,
    .local_ability_advert_word, .an_enable, .an_restart, .speed_duplex,
    .pause_result_select_strap, .partner_ability, .an_complete,
    .collision_test_en);
  epas_mgmt_model mm (.core_clk, .mgmt_index, .mgmt_rd, .mgmt_wr,
    .mgmt_wdata);
  task automatic host(input logic rd, input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [31:0] e);
    @(posedge core_clk);
    #1;
    host_rd = rd;
    host_wr = wr;
    host_addr = a;
    host_wdata = d;
    if (rd) hq.push_back(e);
  endtask
  task automatic idle;
    host(0, 0, ~host_addr, ~host_wdata, 0);
  endtask
  task automatic mread(input logic [4:0] i, input logic [15:0] e);
    mq.push_back(e);
    mm.xfer(1, 0, i, 16'h0, 1);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(negedge core_clk) begin
    if (host_rvalid === 1'b1) begin
      he = hq.pop_front();
      `CHK("host_rdata", he, host_rdata)
    end
    if (mgmt_rvalid === 1'b1) begin
      me = mq.pop_front();
      `CHK("mgmt_rdata", me, mgmt_rdata)
    end
  end
  initial begin
    #20000;
    err_count++;
    $display("ERROR watchdog expired");
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rst = 0;
    sd = 3'($random(seed));
    speed_duplex = sd;
    host(1, 0, EXP_OFFSET, 0, 32'h1);
    host(1, 0, SCS_OFFSET, 0, {27'h0, sd, 2'b0});
    host(1, 0, 12'h800 | 12'($random(seed)), 0, 32'h0);
    idle;
    mm.xfer(0, 1, SCS_INDEX, 16'hffff, 2);
    `CHK("collision_test_en", 1'b1, collision_test_en)
    mread(SCS_INDEX, {8'h0, 1'b1, 2'b0, sd, 2'b0});
    host(0, 1, SCS_OFFSET, 32'h0, 0);
    idle;
    mread(SCS_INDEX, {11'h0, sd, 2'b0});
    fork
      begin
        host(0, 1, SCS_OFFSET, 32'h80, 0);
        idle;
      end
      mm.xfer(0, 1, SCS_INDEX, 16'h0, 0);
    join
    `CHK("write_tie", 1'b1, collision_test_en)
    an_enable = 1;
    for (i = 0; i < 5; i++) begin
      ab = (i == 0) ? 4'h0 : 4'h1 | 4'($random(seed));
      local_ability_advert_word = {4'h0, tbl[i][1:0], 1'b0, ab, 5'h01};
      pause_result_select_strap = tbl[i][2];
      repeat (3) @(posedge core_clk);
      #1 an_restart = 1;
      @(posedge core_clk);
      #1 an_restart = 0;
      n = 0;
      while (an_complete !== 1'b1 && n < 20) begin
        @(posedge core_clk);
        #1 n++;
      end
      `CHK("an_complete", 1'b1, an_complete)
      pa = {2'b01, 2'b00, tbl[i][1], tbl[i][1] ^ tbl[i][0] |
            &tbl[i], 1'b0, 4'hf, 5'h01};
      `CHK("partner_ability", pa, partner_ability)
      host(0, 1, EXP_OFFSET, 32'hffffffff, 0);
      host(1, 0, EXP_OFFSET, 0, {30'h0, 1'b1, i != 0});
      host(1, 0, EXP_OFFSET, 0, {30'h0, 1'b0, i != 0});
      idle;
      mread(EXP_INDEX, {14'h0, 1'b0, i != 0});
      local_ability_advert_word[11:10] = ~tbl[i][1:0];
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("partner_hold", pa, partner_ability)
    end
    // Abort on the last run cycle must not latch the new pause bits
    an_restart = 1;
    @(posedge core_clk);
    #1 an_restart = 0;
    @(posedge core_clk);
    #1 an_enable = 0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("partner_abort", pa, partner_ability)
    `CHK("abort_idle", 1'b0, an_complete)
    repeat (3) @(posedge core_clk);
    `CHK("pending", 0, hq.size() + mq.size())
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ---- testbench/epas_mgmt_model.sv ----
// Management master model for the serial register port.
// Assumes the bench launches requests through xfer.
`timescale 1ns/1ps
`default_nettype none
module epas_mgmt_model (
  input wire logic core_clk,
  output var logic [4:0] mgmt_index,
  output var logic mgmt_rd,
  output var logic mgmt_wr,
  output var logic [15:0] mgmt_wdata
);
  initial begin
    mgmt_index = 5'h00;
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  task automatic xfer(input logic rd, input logic wr, input logic [4:0] i,
                      input logic [15:0] d, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    #1;
    mgmt_rd = rd;
    mgmt_wr = wr;
    mgmt_index = i;
    mgmt_wdata = d;
    @(posedge core_clk);
    #1;
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    // Released lines flip so stale values never look valid
    mgmt_index = ~i;
    mgmt_wdata = ~d;
  endtask
endmodule
`default_nettype wire
